/* core/slcs_pkg.sv */
/*
  Package for the serial-lane configuration and status register block.
  Holds offsets, field positions, reset values and link-state codes.
  Assumes a 32-bit Avalon-MM slave with byte addresses.
*/
package slcs_pkg;

  localparam int unsigned    LANES          = 8;
  localparam int unsigned    HALF_LANES     = 4;
  localparam int unsigned    ADDR_W         = 12;
  localparam int unsigned    DATA_W         = 32;

  // Register byte offsets
  localparam logic [11:0]    OFS_SERDES_CFG = 12'h510;
  localparam logic [11:0]    OFS_LANE_STS0  = 12'h51c;
  localparam logic [11:0]    OFS_LANE_STS1  = 12'h520;
  localparam logic [11:0]    OFS_IRQ_MASK   = 12'h524;

  // Field positions
  localparam int unsigned    FLD_LO         = 0;
  localparam int unsigned    FLD_HI         = 16;
  localparam int unsigned    LSE_BIT        = 16;

  // Reset values
  localparam logic [7:0]     FORCE_RST      = 8'h00;
  localparam logic           LSE_RST        = 1'h0;
  localparam logic [7:0]     FLAGS_RST      = 8'h00;
  localparam logic [31:0]    MASK_RST       = 32'h0000_0000;
  localparam logic [31:0]    UNMAPPED_RD    = 32'h0000_0000;

  // Link training state encoding seen on the ltssm_state input
  typedef enum logic [2:0] {
    SLCS_LT_DETECT    = 3'h0,
    SLCS_LT_POLLING   = 3'h1,
    SLCS_LT_CONFIG    = 3'h2,
    SLCS_LT_L0        = 3'h3,
    SLCS_LT_RECOVERY  = 3'h4,
    SLCS_LT_DISABLED  = 3'h5,
    SLCS_LT_HOT_RESET = 3'h6,
    SLCS_LT_OTHER     = 3'h7
  } slcs_ltssm_e;

endpackage : slcs_pkg

/* core/slcs_lane_regs.sv */
/*
  Serial-lane configuration and status register block of one switch port.
  Holds receiver_detect_force, low_swing_enable and four per-lane sticky
  error fields with a level interrupt. Assumes event inputs are one-cycle
  pulses synchronous to core_clk, and that hot_reset is a non-fundamental
  reset pulse which leaves all software-sticky state alone.
*/
// Chosen here: the Avalon-MM interface to the registers.
// Behaviour
// - Per-lane bit forces far-end receiver detected
// - Even port: upper lanes only when merged
// - Odd port: upper four lanes undefined
// - Override ignored in serial-lane test mode
// - Config bit 16 selects low swing
// - Disparity error sets sticky bit, write-one clears
// - Disparity, underflow, overflow captured only in L0
// - Decode error sets sticky bit, write-one clears
// - Decode errors captured in L0/Config/Disabled/HotReset
// - Underflow sets sticky bit, write-one clears
// - Overflow sets sticky bit, write-one clears
`timescale 1ns/100ps
module slcs_lane_regs
  import slcs_pkg::*;
#(
  parameter bit ODD_PORT = 1'b0
) (
  // Clock and fundamental reset
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  // Non-fundamental reset, keeps sticky state
  input  wire logic                          hot_reset,
  // Avalon-MM slave
  input  wire logic [slcs_pkg::ADDR_W-1:0]   avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [slcs_pkg::DATA_W-1:0]   avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic      [slcs_pkg::DATA_W-1:0]   avs_readdata,
  output logic                               avs_waitrequest,
  // Port mode
  input  wire logic                          merged_mode,
  input  wire logic                          serdes_test_mode,
  input  wire logic [2:0]                    ltssm_state,
  // Lane receiver events
  input  wire logic [slcs_pkg::LANES-1:0]    rx_disparity_err,
  input  wire logic [slcs_pkg::LANES-1:0]    rx_decode_err,
  input  wire logic [slcs_pkg::LANES-1:0]    rx_underflow,
  input  wire logic [slcs_pkg::LANES-1:0]    rx_overflow,
  // Lane controls
  input  wire logic [slcs_pkg::LANES-1:0]    rx_detect_raw,
  output logic      [slcs_pkg::LANES-1:0]    rx_detected,
  output logic                               tx_low_swing,
  // Interrupt
  output logic                               irq
);
  import slcs_pkg::*;

  logic [LANES-1:0]  force_r;
  logic              lse_r;
  logic [LANES-1:0]  disp_r;
  logic [LANES-1:0]  dec_r;
  logic [LANES-1:0]  und_r;
  logic [LANES-1:0]  ovr_r;
  logic [31:0]       mask_r;
  logic [31:0]       rdata_r;
  logic              ack_r;
  logic [LANES-1:0]  rx_detected_r;
  logic              tx_low_swing_r;
  logic              irq_r;

  // One wait cycle: request taken on the first edge, answer on the second
  wire               req        = (avs_read | avs_write) & ~ack_r;
  wire               wr_go      = avs_write & req;
  wire               sel_cfg    = avs_address == OFS_SERDES_CFG;
  wire               sel_sts0   = avs_address == OFS_LANE_STS0;
  wire               sel_sts1   = avs_address == OFS_LANE_STS1;
  wire               sel_mask   = avs_address == OFS_IRQ_MASK;
  wire [31:0]        be_mask    = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [31:0]        wdata_m    = avs_writedata & be_mask;

  // Lanes whose upper half carries meaning on this port
  wire               upper_ok   = ~ODD_PORT & merged_mode;
  wire [LANES-1:0]   lane_ok    = {{HALF_LANES{upper_ok}}, {HALF_LANES{1'b1}}};

  wire               in_l0      = ltssm_state == SLCS_LT_L0;
  wire               dec_ok     = in_l0 | (ltssm_state == SLCS_LT_CONFIG)
                                  | (ltssm_state == SLCS_LT_DISABLED)
                                  | (ltssm_state == SLCS_LT_HOT_RESET);

  wire [LANES-1:0]   disp_set   = rx_disparity_err & lane_ok & {LANES{in_l0}};
  wire [LANES-1:0]   dec_set    = rx_decode_err & lane_ok & {LANES{dec_ok}};
  wire [LANES-1:0]   und_set    = rx_underflow & lane_ok & {LANES{in_l0}};
  wire [LANES-1:0]   ovr_set    = rx_overflow & lane_ok & {LANES{in_l0}};

  wire [LANES-1:0]   clr_disp   = {LANES{wr_go & sel_sts0}} & wdata_m[FLD_LO +: LANES];
  wire [LANES-1:0]   clr_dec    = {LANES{wr_go & sel_sts0}} & wdata_m[FLD_HI +: LANES];
  wire [LANES-1:0]   clr_und    = {LANES{wr_go & sel_sts1}} & wdata_m[FLD_LO +: LANES];
  wire [LANES-1:0]   clr_ovr    = {LANES{wr_go & sel_sts1}} & wdata_m[FLD_HI +: LANES];

  wire [31:0]        cfg_word   = {15'h0000, lse_r, 8'h00, force_r};
  wire [31:0]        sts0_word  = {8'h00, dec_r, 8'h00, disp_r};
  wire [31:0]        sts1_word  = {8'h00, ovr_r, 8'h00, und_r};
  wire [31:0]        rd_mux     = sel_cfg  ? cfg_word  :
                                  sel_sts0 ? sts0_word :
                                  sel_sts1 ? sts1_word :
                                  sel_mask ? mask_r    : UNMAPPED_RD;

  // Pending unmasked sticky bits, next-cycle value so irq tracks the flags
  wire [LANES-1:0]   disp_nxt   = (disp_r & ~clr_disp) | disp_set;
  wire [LANES-1:0]   dec_nxt    = (dec_r & ~clr_dec) | dec_set;
  wire [LANES-1:0]   und_nxt    = (und_r & ~clr_und) | und_set;
  wire [LANES-1:0]   ovr_nxt    = (ovr_r & ~clr_ovr) | ovr_set;
  wire [31:0]        sts0_nxt   = {8'h00, dec_nxt, 8'h00, disp_nxt};
  wire [31:0]        sts1_nxt   = {8'h00, ovr_nxt, 8'h00, und_nxt};
  wire [31:0]        mask_nxt   = (wr_go & sel_mask) ? wdata_m | (mask_r & ~be_mask) : mask_r;
  wire               irq_nxt    = |((sts0_nxt | sts1_nxt) & mask_nxt);

  // Test mode keeps the raw detect result
  wire [LANES-1:0]   force_eff  = force_r & lane_ok & {LANES{~serdes_test_mode}};

  // Bus handshake; hot_reset does not touch software state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r   <= 1'b0;
      rdata_r <= UNMAPPED_RD;
    end else begin
      ack_r   <= req;
      rdata_r <= req ? rd_mux : rdata_r;
    end
  end

  // Configuration; survives hot reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      force_r <= FORCE_RST;
      lse_r   <= LSE_RST;
    end else if (wr_go && sel_cfg) begin
      if (avs_byteenable[0]) force_r <= avs_writedata[FLD_LO +: LANES];
      if (avs_byteenable[2]) lse_r   <= avs_writedata[LSE_BIT];
    end
  end

  // Sticky flags: set wins over a same-cycle write-one clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      disp_r <= FLAGS_RST;
      dec_r  <= FLAGS_RST;
      und_r  <= FLAGS_RST;
      ovr_r  <= FLAGS_RST;
    end else begin
      disp_r <= disp_nxt;
      dec_r  <= dec_nxt;
      und_r  <= und_nxt;
      ovr_r  <= ovr_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r         <= MASK_RST;
      irq_r          <= 1'b0;
      rx_detected_r  <= '0;
      tx_low_swing_r <= LSE_RST;
    end else begin
      mask_r         <= mask_nxt;
      irq_r          <= irq_nxt;
      rx_detected_r  <= rx_detect_raw | force_eff;
      tx_low_swing_r <= lse_r;
    end
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = ~ack_r;
  assign rx_detected     = rx_detected_r;
  assign tx_low_swing    = tx_low_swing_r;
  assign irq             = irq_r;

  property p_disp_gate;
    @(posedge core_clk) disable iff (!rst_n)
      (ltssm_state != SLCS_LT_L0) && !(wr_go && sel_sts0) |=> disp_r == $past(disp_r);
  endproperty
  a_disp_gate: assert property (p_disp_gate) else $error("disparity flag set outside L0");

  property p_disp_set;
    @(posedge core_clk) disable iff (!rst_n)
      in_l0 && rx_disparity_err[0] |=> disp_r[0];
  endproperty
  a_disp_set: assert property (p_disp_set) else $error("disparity flag missed");

  property p_dec_set;
    @(posedge core_clk) disable iff (!rst_n)
      (ltssm_state == SLCS_LT_CONFIG) && rx_decode_err[1] |=> dec_r[1];
  endproperty
  a_dec_set: assert property (p_dec_set) else $error("decode flag missed in config");

  property p_dec_gate;
    @(posedge core_clk) disable iff (!rst_n)
      (ltssm_state == SLCS_LT_RECOVERY) && !dec_r[2] |=> !dec_r[2];
  endproperty
  a_dec_gate: assert property (p_dec_gate) else $error("decode flag set in recovery");

  property p_und_clr;
    @(posedge core_clk) disable iff (!rst_n)
      wr_go && sel_sts1 && avs_byteenable[0] && avs_writedata[0] && !und_set[0] |=> !und_r[0];
  endproperty
  a_und_clr: assert property (p_und_clr) else $error("underflow flag not cleared");

  property p_ovr_set;
    @(posedge core_clk) disable iff (!rst_n)
      in_l0 && rx_overflow[3] |=> ovr_r[3];
  endproperty
  a_ovr_set: assert property (p_ovr_set) else $error("overflow flag missed");

  property p_upper_gate;
    @(posedge core_clk) disable iff (!rst_n)
      !upper_ok && !und_r[7] |=> !und_r[7];
  endproperty
  a_upper_gate: assert property (p_upper_gate) else $error("upper lane set when invalid");

  property p_force;
    @(posedge core_clk) disable iff (!rst_n)
      force_r[0] && !serdes_test_mode |=> rx_detected[0];
  endproperty
  a_force: assert property (p_force) else $error("override did not force detect");

  property p_test_mode;
    @(posedge core_clk) disable iff (!rst_n)
      serdes_test_mode |=> rx_detected == $past(rx_detect_raw);
  endproperty
  a_test_mode: assert property (p_test_mode) else $error("override active in test mode");

  property p_lse;
    @(posedge core_clk) disable iff (!rst_n)
      wr_go && sel_cfg && avs_byteenable[2] |=> ##1 tx_low_swing == $past(avs_writedata[LSE_BIT], 2);
  endproperty
  a_lse: assert property (p_lse) else $error("low swing not following bit 16");

  property p_hot;
    @(posedge core_clk) disable iff (!rst_n)
      hot_reset && !avs_write |=> force_r == $past(force_r) && lse_r == $past(lse_r);
  endproperty
  a_hot: assert property (p_hot) else $error("config lost on hot reset");

endmodule : slcs_lane_regs

/* verification/slcs_lane_model.sv */
/*
  Behavioural far-end lane model: receiver events and analog detect.
  Assumes events are seen by the block as one-cycle pulses on core_clk.
*/
`timescale 1ns/100ps
module slcs_lane_model
  import slcs_pkg::*;
(
  // Clock
  input  wire logic                       core_clk,
  // Lane events and detect
  output logic [slcs_pkg::LANES-1:0]      rx_disparity_err,
  output logic [slcs_pkg::LANES-1:0]      rx_decode_err,
  output logic [slcs_pkg::LANES-1:0]      rx_underflow,
  output logic [slcs_pkg::LANES-1:0]      rx_overflow,
  output logic [slcs_pkg::LANES-1:0]      rx_detect_raw
);
  import slcs_pkg::*;
  initial begin
    {rx_disparity_err, rx_decode_err, rx_underflow, rx_overflow, rx_detect_raw} = '0;
  end
  // One high cycle only: a longer pulse would set the flag again after a write-one clear
  task automatic fire(input logic [1:0] kind, input logic [7:0] lanes);
    @(posedge core_clk);
    case (kind)
      2'h0: rx_disparity_err <= lanes;
      2'h1: rx_decode_err <= lanes;
      2'h2: rx_underflow <= lanes;
      default: rx_overflow <= lanes;
    endcase
    @(posedge core_clk);
    {rx_disparity_err, rx_decode_err, rx_underflow, rx_overflow} <= '0;
  endtask : fire
  task automatic set_raw(input logic [7:0] v);
    rx_detect_raw <= v;
  endtask : set_raw
endmodule : slcs_lane_model

/* verification/tb_top.sv */
/*
  Bench for the lane register block: event capture table, then clearing,
  interrupt, config and reset cases. Assumes the lane model drives events.
*/
`timescale 1ns/100ps
module tb_top;
  import slcs_pkg::*;
  typedef struct packed {
    slcs_ltssm_e lt; logic [1:0] kind; logic mrg; logic [7:0] lanes; logic [7:0] exp;
  } slcs_row_s;
  logic        core_clk = 0, rst_n = 0, hot_reset = 0, avs_read = 0, avs_write = 0;
  logic        merged_mode = 1, serdes_test_mode = 0, avs_waitrequest, tx_low_swing, irq;
  logic [11:0] avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, rd;
  logic [3:0]  be = 4'hf;
  logic [2:0]  ltssm_state = 3'h0;
  logic [7:0]  rx_disparity_err, rx_decode_err, rx_underflow, rx_overflow;
  logic [7:0]  rx_detect_raw, rx_detected;
  int          miscompares = 0, n_checks = 0, cycles = 0;
  logic [11:0] addrs [5] = '{12'h510, 12'h51c, 12'h520, 12'h524, 12'h600};
  slcs_row_s   rows [12] = '{
    '{SLCS_LT_L0, 2'h0, 1'h1, 8'ha5, 8'ha5}, '{SLCS_LT_RECOVERY, 2'h0, 1'h1, 8'hff, 8'h00},
    '{SLCS_LT_L0, 2'h1, 1'h0, 8'hf3, 8'h03}, '{SLCS_LT_CONFIG, 2'h1, 1'h1, 8'h81, 8'h81},
    '{SLCS_LT_DISABLED, 2'h1, 1'h1, 8'h10, 8'h10}, '{SLCS_LT_HOT_RESET, 2'h1, 1'h1, 8'h02, 8'h02},
    '{SLCS_LT_POLLING, 2'h1, 1'h1, 8'hff, 8'h00}, '{SLCS_LT_L0, 2'h2, 1'h1, 8'h3c, 8'h3c},
    '{SLCS_LT_CONFIG, 2'h2, 1'h1, 8'hff, 8'h00}, '{SLCS_LT_L0, 2'h3, 1'h0, 8'hff, 8'h0f},
    '{SLCS_LT_DETECT, 2'h3, 1'h1, 8'hff, 8'h00}, '{SLCS_LT_RECOVERY, 2'h1, 1'h1, 8'h04, 8'h00}};

  always #4 core_clk = ~core_clk;

  slcs_lane_regs uut (.core_clk, .rst_n, .hot_reset, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(be), .avs_readdata, .avs_waitrequest, .merged_mode,
    .serdes_test_mode, .ltssm_state, .rx_disparity_err, .rx_decode_err, .rx_underflow,
    .rx_overflow, .rx_detect_raw, .rx_detected, .tx_low_swing, .irq);
  slcs_lane_model u_lane (.core_clk, .rx_disparity_err, .rx_decode_err, .rx_underflow,
    .rx_overflow, .rx_detect_raw);

  task automatic report_and_stop;
    $display("checks %0d, miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      report_and_stop;
    end
  end

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= d;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, '0);
    chk("readdata", e, rd);
  endtask : rchk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  initial begin
    tick(20);
    rst_n <= 1'b1;
    foreach (addrs[i]) rchk(addrs[i], '0);
    foreach (rows[i]) begin
      bus(1'b1, 12'h51c, '1);
      bus(1'b1, 12'h520, '1);
      ltssm_state <= rows[i].lt;
      merged_mode <= rows[i].mrg;
      u_lane.fire(rows[i].kind, rows[i].lanes);
      rchk(rows[i].kind[1] ? 12'h520 : 12'h51c, rows[i].kind[0] ? {8'h0, rows[i].exp, 16'h0}
        : {24'h0, rows[i].exp});
    end
    ltssm_state <= SLCS_LT_L0;
    u_lane.fire(2'h0, 8'hff);
    bus(1'b1, 12'h51c, 32'h0000_000f);
    rchk(12'h51c, 32'h0000_00f0);
    tick(2);
    chk("irq", '0, irq);
    bus(1'b1, 12'h524, 32'h0000_0080);
    tick(2);
    chk("irq", 32'h1, irq);
    bus(1'b1, 12'h51c, 32'h0000_0080);
    tick(2);
    chk("irq", '0, irq);
    be <= 4'h1;
    bus(1'b1, 12'h510, '1);
    be <= 4'hf;
    rchk(12'h510, 32'h0000_00ff);
    tick(2);
    chk("rx_detected", 32'hff, rx_detected);
    merged_mode <= 1'b0;
    tick(2);
    chk("rx_detected", 32'h0f, rx_detected);
    serdes_test_mode <= 1'b1;
    u_lane.set_raw(8'h02);
    tick(2);
    chk("rx_detected", 32'h02, rx_detected);
    serdes_test_mode <= 1'b0;
    bus(1'b1, 12'h510, 32'h0001_0000);
    tick(2);
    chk("tx_low_swing", 32'h1, tx_low_swing);
    hot_reset <= 1'b1;
    tick(1);
    hot_reset <= 1'b0;
    bus(1'b1, 12'h600, '1);
    rchk(12'h510, 32'h0001_0000);
    rchk(12'h51c, 32'h0000_0070);
    rchk(12'h600, '0);
    bus(1'b1, 12'h510, '0);
    tick(2);
    chk("tx_low_swing", '0, tx_low_swing);
    u_lane.fire(2'h3, 8'h01);
    rchk(12'h520, 32'h0001_0000);
    rst_n <= 1'b0;
    tick(2);
    rst_n <= 1'b1;
    rchk(12'h520, '0);
    report_and_stop;
  end
endmodule : tb_top
